// ==== core/fsp_slave_port.sv ====
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Reset abandons work, clears status register and empties FIFOs.
// - Runs from host bus clock plus its inverted complement.
// - Each strobed bus cycle moves exactly one 32-bit word one way.
// - Host strobes every cycle; controller tracks protocol from status lines.
// - Status code is sampled at the strobed clock edge.
// - Monadic register source needs no words; dyadic register-memory needs one word if single, two if double.
// - Operands go into FIFO; instruction becomes register form, same number.
// - Operand FIFO holds up to ten single or double entries.
// - Memory destination: wait for completion, latch result and pulse done in the same cycle.
// - New instruction before operands or result finish aborts the old one.
// - Write strobe with code 11110 flushes all executing instructions.
// - Pipelined mode accepts up to four instructions before first completion.
// - After status request, host reads status word; bit 0 is trap-pending.
// - Trap-type bit selects undefined-opcode trap or slave trap.
// - Trap drives status request low one clock and sets trap-pending bit.
module fsp_slave_port (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        bclkInv,
  input  wire logic        slaveStrobeN,
  input  wire logic [4:0]  hostStatusCode,
  input  wire logic        hostRead,
  input  wire logic [31:0] hostDataIn,
  output logic [31:0]      hostDataOut,
  output logic             hostDataOe,
  output logic             slaveDoneN,
  output logic             statusRequestN,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr
);
  fsp_pkg::fsp_state_t state, next_state;
  fsp_pkg::fsp_instr_t curInstr, next_curInstr, decoded;
  fsp_pkg::fsp_opnd_t  pushData, popData;
  logic [2:0]  outstanding, next_outstanding;
  logic [2:0]  wordsLeft, next_wordsLeft;
  logic        halfHeld, next_halfHeld;
  logic [31:0] lowHalf, next_lowHalf;
  logic [63:0] resOut, next_resOut;
  logic        resIdx, next_resIdx;
  logic        trapQ, next_trapQ;
  logic        trapTs, next_trapTs;
  logic [7:0]  abortCnt, next_abortCnt;
  logic [31:0] next_hostDataOut;
  logic        next_hostDataOe, next_slaveDoneN, next_statusRequestN;
  logic        pushValid, pushReady, popValid, fifoClear;
  logic [3:0]  fifoCount;
  // APB side state
  logic        pipeMode, next_pipeMode;
  logic [31:0] resLo, next_resLo, resHi, next_resHi;
  logic [31:0] fp_status_register, next_fsr;
  logic [2:0]  flags, next_flags;
  logic        clkErr, next_clkErr;
  logic [31:0] next_prdata;
  logic        next_pready, next_pslverr;
  logic        access, doneReq, trapReq, popReq;
  // Host cycle kinds
  logic        hostCyc, isId, isOpW, isResRd, isStRd, isFlush, canDone;
  logic [31:0] statusWord;

  fsp_decode u_decode (
    .idWord (hostDataIn),
    .instr  (decoded)
  );

  fsp_operand_fifo u_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .clear     (fifoClear),
    .pushValid (pushValid),
    .pushReady (pushReady),
    .pushData  (pushData),
    .popValid  (popValid),
    .popReady  (popReq),
    .popData   (popData),
    .count     (fifoCount)
  );

  // Strobe edge samples status and data
  assign hostCyc = !slaveStrobeN;
  assign isId    = hostCyc && hostStatusCode == fsp_pkg::ST_ID && !hostRead;
  assign isOpW   = hostCyc && hostStatusCode == fsp_pkg::ST_OPER && !hostRead;
  assign isResRd = hostCyc && hostStatusCode == fsp_pkg::ST_OPER && hostRead;
  assign isStRd  = hostCyc && hostStatusCode == fsp_pkg::ST_STAT && hostRead;
  assign isFlush = hostCyc && hostStatusCode == fsp_pkg::ST_STAT && !hostRead;

  assign access  = psel && penable && pready;
  assign doneReq = access && pwrite && paddr == fsp_pkg::A_CTRL && pwdata[fsp_pkg::C_DONE];
  assign trapReq = access && pwrite && paddr == fsp_pkg::A_CTRL && pwdata[fsp_pkg::C_TRAP];
  assign popReq  = access && !pwrite && paddr == fsp_pkg::A_OPHI;
  // Completion only for an instruction whose operands are all in
  assign canDone = outstanding != 3'h0 && state != fsp_pkg::S_RESULT
                   && (state == fsp_pkg::S_EXEC || outstanding > 3'h1);

  always_comb begin
    statusWord = 32'h0;
    statusWord[fsp_pkg::SW_Q]  = trapQ;
    statusWord[fsp_pkg::SW_TS] = trapTs;
    statusWord[fsp_pkg::SW_L]  = flags[0];
    statusWord[fsp_pkg::SW_Z]  = flags[1];
    statusWord[fsp_pkg::SW_N]  = flags[2];
  end

  // Protocol sequencer: flush, new instruction, operand, result, status
  always_comb begin
    next_state          = state;
    next_curInstr       = curInstr;
    next_outstanding    = outstanding;
    next_wordsLeft      = wordsLeft;
    next_halfHeld       = halfHeld;
    next_lowHalf        = lowHalf;
    next_resOut         = resOut;
    next_resIdx         = resIdx;
    next_trapQ          = trapQ;
    next_trapTs         = trapTs;
    next_abortCnt       = abortCnt;
    next_hostDataOut    = hostDataOut;
    next_hostDataOe     = 1'b0;
    next_slaveDoneN     = 1'b1;
    next_statusRequestN = 1'b1;
    pushValid           = 1'b0;
    pushData            = '0;
    fifoClear           = 1'b0;
    if (isFlush) begin
      next_state       = fsp_pkg::S_IDLE;
      next_outstanding = 3'h0;
      next_wordsLeft   = 3'h0;
      next_halfHeld    = 1'b0;
      next_trapQ       = 1'b0;
      fifoClear        = 1'b1;
    end else if (isId) begin
      if (state == fsp_pkg::S_OPER || state == fsp_pkg::S_RESULT) begin
        next_abortCnt    = abortCnt + 8'h1;
        next_outstanding = 3'h1;
        fifoClear        = 1'b1;
      end else if (state == fsp_pkg::S_IDLE) begin
        next_outstanding = 3'h1;
      end else if (pipeMode && curInstr.pipeOk && outstanding < fsp_pkg::MAX_PIPE) begin
        next_outstanding = outstanding + 3'h1;
      end else begin
        // Host broke the pipe rules: restart on the new one
        next_abortCnt    = abortCnt + 8'h1;
        next_outstanding = 3'h1;
      end
      next_curInstr  = decoded;
      next_wordsLeft = decoded.opWords;
      next_halfHeld  = 1'b0;
      next_trapQ     = 1'b0;
      next_trapTs    = 1'b0;
      next_state     = (decoded.opWords == 3'h0) ? fsp_pkg::S_EXEC : fsp_pkg::S_OPER;
    end else if (isOpW && state == fsp_pkg::S_OPER) begin
      if (curInstr.dbl && !halfHeld) begin
        next_lowHalf  = hostDataIn;
        next_halfHeld = 1'b1;
      end else begin
        pushValid     = 1'b1;
        pushData.dbl  = curInstr.dbl;
        pushData.data = curInstr.dbl ? {hostDataIn, lowHalf} : {32'h0, hostDataIn};
        next_halfHeld = 1'b0;
      end
      next_wordsLeft = wordsLeft - 3'h1;
      if (wordsLeft == 3'h1) next_state = fsp_pkg::S_EXEC;
    end else if (isResRd && state == fsp_pkg::S_RESULT) begin
      next_hostDataOut = resIdx ? resOut[63:32] : resOut[31:0];
      next_hostDataOe  = 1'b1;
      next_resIdx      = 1'b1;
      if (resIdx || !curInstr.dbl) begin
        next_state       = fsp_pkg::S_IDLE;
        next_outstanding = 3'h0;
      end
    end else if (isStRd) begin
      next_hostDataOut = statusWord;
      next_hostDataOe  = 1'b1;
    end
    // Completion from the datapath side
    if (!isFlush && !isId && canDone) begin
      if (trapReq) begin
        next_statusRequestN = 1'b0;
        next_trapQ          = 1'b1;
        next_trapTs         = pwdata[fsp_pkg::C_TTYPE];
        next_outstanding    = 3'h0;
        next_state          = fsp_pkg::S_IDLE;
        fifoClear           = 1'b1;
      end else if (doneReq) begin
        next_slaveDoneN  = 1'b0;
        next_outstanding = outstanding - 3'h1;
        if (curInstr.wantResult && outstanding == 3'h1) begin
          next_resOut = {resHi, resLo};
          next_resIdx = 1'b0;
          next_state  = fsp_pkg::S_RESULT;
        end else if (outstanding == 3'h1) begin
          next_state = fsp_pkg::S_IDLE;
        end
      end
    end
  end

  // Sequencer registers; reset clears everything
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state          <= fsp_pkg::S_IDLE;
      curInstr       <= '0;
      outstanding    <= 3'h0;
      wordsLeft      <= 3'h0;
      halfHeld       <= 1'b0;
      lowHalf        <= 32'h0;
      resOut         <= 64'h0;
      resIdx         <= 1'b0;
      trapQ          <= 1'b0;
      trapTs         <= 1'b0;
      abortCnt       <= 8'h0;
      hostDataOut    <= 32'h0;
      hostDataOe     <= 1'b0;
      slaveDoneN     <= 1'b1;
      statusRequestN <= 1'b1;
    end else begin
      state          <= next_state;
      curInstr       <= next_curInstr;
      outstanding    <= next_outstanding;
      wordsLeft      <= next_wordsLeft;
      halfHeld       <= next_halfHeld;
      lowHalf        <= next_lowHalf;
      resOut         <= next_resOut;
      resIdx         <= next_resIdx;
      trapQ          <= next_trapQ;
      trapTs         <= next_trapTs;
      abortCnt       <= next_abortCnt;
      hostDataOut    <= next_hostDataOut;
      hostDataOe     <= next_hostDataOe;
      slaveDoneN     <= next_slaveDoneN;
      statusRequestN <= next_statusRequestN;
    end
  end

  // APB slave: read data captured in setup, no wait states
  always_comb begin
    next_pipeMode = pipeMode;
    next_resLo    = resLo;
    next_resHi    = resHi;
    next_fsr      = fp_status_register;
    next_flags    = flags;
    // Complement must be low at every rising edge
    next_clkErr   = clkErr | bclkInv;
    next_pready   = psel && !penable;
    next_prdata   = prdata;
    next_pslverr  = 1'b0;
    if (psel && !penable) begin
      next_prdata = 32'h0;
      unique case (paddr)
        fsp_pkg::A_CTRL:  next_prdata = {31'h0, pipeMode};
        fsp_pkg::A_STAT:  next_prdata = {abortCnt, 10'h0, clkErr, halfHeld, wordsLeft,
                                         outstanding, fifoCount, state};
        fsp_pkg::A_INSTR: next_prdata = {8'h0, curInstr.conv};
        fsp_pkg::A_RESLO: next_prdata = resLo;
        fsp_pkg::A_RESHI: next_prdata = resHi;
        fsp_pkg::A_OPLO:  next_prdata = popValid ? popData.data[31:0] : 32'h0;
        fsp_pkg::A_OPHI:  next_prdata = popValid ? popData.data[63:32] : 32'h0;
        fsp_pkg::A_FSR:   next_prdata = fp_status_register;
        fsp_pkg::A_FLAGS: next_prdata = {29'h0, flags};
        default:          next_pslverr = 1'b1;
      endcase
    end
    if (access && pwrite) begin
      unique case (paddr)
        fsp_pkg::A_CTRL:  next_pipeMode = pwdata[fsp_pkg::C_PIPE];
        fsp_pkg::A_RESLO: next_resLo = pwdata;
        fsp_pkg::A_RESHI: next_resHi = pwdata;
        fsp_pkg::A_FSR:   next_fsr = pwdata;
        fsp_pkg::A_FLAGS: next_flags = pwdata[2:0];
        default:          next_pslverr = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pipeMode <= 1'b0;
      resLo    <= 32'h0;
      resHi    <= 32'h0;
      fp_status_register      <= 32'h0;
      flags    <= 3'h0;
      clkErr   <= 1'b0;
      prdata   <= 32'h0;
      pready   <= 1'b0;
      pslverr  <= 1'b0;
    end else begin
      pipeMode <= next_pipeMode;
      resLo    <= next_resLo;
      resHi    <= next_resHi;
      fp_status_register      <= next_fsr;
      flags    <= next_flags;
      clkErr   <= next_clkErr;
      prdata   <= next_prdata;
      pready   <= next_pready;
      pslverr  <= next_pslverr;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_done_pulse;
    $fell(slaveDoneN) |=> slaveDoneN ##1 slaveDoneN;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done pulse not one cycle");
  property p_sreq_pulse;
    $fell(statusRequestN) |=> statusRequestN;
  endproperty
  a_sreq_pulse: assert property (p_sreq_pulse) else $error("status request not one cycle");
  property p_trap_q;
    $fell(statusRequestN) |-> trapQ && state == fsp_pkg::S_IDLE;
  endproperty
  a_trap_q: assert property (p_trap_q) else $error("trap without pending bit");
  property p_fifo_cap;
    fifoCount <= 4'(fsp_pkg::FIFO_DEPTH);
  endproperty
  a_fifo_cap: assert property (p_fifo_cap) else $error("operand FIFO over ten");
  property p_flush;
    isFlush |=> state == fsp_pkg::S_IDLE && outstanding == 3'h0 && fifoCount == 4'h0;
  endproperty
  a_flush: assert property (p_flush) else $error("soft reset did not flush");
  property p_abort;
    isId && state == fsp_pkg::S_OPER |=> abortCnt == $past(abortCnt) + 8'h1 && outstanding == 3'h1;
  endproperty
  a_abort: assert property (p_abort) else $error("old instruction not aborted");
  property p_pipe_cap;
    outstanding <= fsp_pkg::MAX_PIPE;
  endproperty
  a_pipe_cap: assert property (p_pipe_cap) else $error("more than four in flight");
  property p_read_word;
    (isResRd && state == fsp_pkg::S_RESULT) || isStRd |=> hostDataOe ##1 !hostDataOe;
  endproperty
  a_read_word: assert property (p_read_word) else $error("read not one word");
  property p_result_wait;
    $fell(slaveDoneN) && curInstr.wantResult && outstanding == 3'h0 |-> state == fsp_pkg::S_RESULT;
  endproperty
  a_result_wait: assert property (p_result_wait) else $error("result not held");

  c_pipe4: cover property (outstanding == fsp_pkg::MAX_PIPE);
  c_trap: cover property ($fell(statusRequestN) && trapTs);
  c_result2: cover property (state == fsp_pkg::S_RESULT && resIdx ##1 state == fsp_pkg::S_IDLE);
endmodule
`default_nettype wire

// ==== pkg/fsp_pkg.sv ====
package fsp_pkg;
  // Host status codes
  localparam logic [4:0]  ST_ID        = 5'h1f;
  localparam logic [4:0]  ST_OPER      = 5'h1d;
  localparam logic [4:0]  ST_STAT      = 5'h1e;
  // Sizes
  localparam int          FIFO_DEPTH   = 10;
  localparam logic [2:0]  MAX_PIPE     = 3'h4;
  // APB byte offsets
  localparam logic [11:0] A_CTRL       = 12'h000;
  localparam logic [11:0] A_STAT       = 12'h004;
  localparam logic [11:0] A_INSTR      = 12'h008;
  localparam logic [11:0] A_RESLO      = 12'h00c;
  localparam logic [11:0] A_RESHI      = 12'h010;
  localparam logic [11:0] A_OPLO       = 12'h014;
  localparam logic [11:0] A_OPHI       = 12'h018;
  localparam logic [11:0] A_FSR        = 12'h01c;
  localparam logic [11:0] A_FLAGS      = 12'h020;
  // Control bits
  localparam int          C_PIPE       = 0;
  localparam int          C_DONE       = 1;
  localparam int          C_TRAP       = 2;
  localparam int          C_TTYPE      = 3;
  // Status word bits
  localparam int          SW_Q         = 0;
  localparam int          SW_TS        = 1;
  localparam int          SW_L         = 2;
  localparam int          SW_Z         = 6;
  localparam int          SW_N         = 7;
  // Operation word fields
  localparam int          OW_FIRST_GENERAL_OPERAND      = 11;
  localparam int          OW_SECOND_GENERAL_OPERAND      = 6;
  localparam int          OW_OP        = 2;
  localparam int          OW_F         = 0;
  localparam logic [3:0]  OP_ADD       = 4'h0;
  localparam logic [3:0]  OP_SUB       = 4'h4;
  localparam logic [3:0]  OP_MUL       = 4'hc;
  localparam logic [3:0]  OP_DIV       = 4'h8;
  localparam logic [3:0]  OP_CMP       = 4'h2;

  typedef enum logic [1:0] {S_IDLE, S_OPER, S_EXEC, S_RESULT} fsp_state_t;

  typedef struct packed {
    logic        dbl;
    logic [63:0] data;
  } fsp_opnd_t;

  typedef struct packed {
    logic [23:0] conv;
    logic [2:0]  opWords;
    logic        wantResult;
    logic        pipeOk;
    logic        dbl;
  } fsp_instr_t;
endpackage

// ==== core/fsp_decode.sv ====
`timescale 1ns/1ps
`default_nettype none
module fsp_decode (
  input  wire logic [31:0]     idWord,
  output fsp_pkg::fsp_instr_t  instr
);
  logic [15:0] opw;
  logic [4:0]  first_general_operand;
  logic [4:0]  second_general_operand;
  logic [3:0]  op;
  logic        mem1;
  logic        mem2;
  logic        dyadic;
  logic [2:0]  per;

  // Opcode bytes arrive swapped
  assign opw    = {idWord[15:8], idWord[23:16]};
  assign first_general_operand   = opw[fsp_pkg::OW_FIRST_GENERAL_OPERAND +: 5];
  assign second_general_operand   = opw[fsp_pkg::OW_SECOND_GENERAL_OPERAND +: 5];
  assign op     = opw[fsp_pkg::OW_OP +: 4];
  // Register mode has the top two gen bits clear
  assign mem1   = first_general_operand[4:3] != 2'h0;
  assign mem2   = second_general_operand[4:3] != 2'h0;
  assign dyadic = op == fsp_pkg::OP_ADD || op == fsp_pkg::OP_SUB || op == fsp_pkg::OP_MUL
                  || op == fsp_pkg::OP_DIV || op == fsp_pkg::OP_CMP;
  assign per    = opw[fsp_pkg::OW_F] ? 3'h1 : 3'h2;

  // Word count and register form
  always_comb begin
    instr.opWords    = (mem1 ? per : 3'h0) + ((dyadic && mem2) ? per : 3'h0);
    instr.wantResult = mem2 && op != fsp_pkg::OP_CMP;
    instr.pipeOk     = op != fsp_pkg::OP_CMP;
    instr.dbl        = !opw[fsp_pkg::OW_F];
    instr.conv       = {idWord[31:24], 2'h0, first_general_operand[2:0], 2'h0, second_general_operand[2:0], opw[5:0]};
  end
endmodule
`default_nettype wire

// ==== core/fsp_operand_fifo.sv ====
`timescale 1ns/1ps
`default_nettype none
module fsp_operand_fifo (
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire logic                clear,
  input  wire logic                pushValid,
  output logic                     pushReady,
  input  wire fsp_pkg::fsp_opnd_t  pushData,
  output logic                     popValid,
  input  wire logic                popReady,
  output fsp_pkg::fsp_opnd_t       popData,
  output logic [3:0]               count
);
  fsp_pkg::fsp_opnd_t mem [fsp_pkg::FIFO_DEPTH];
  logic [3:0] wrPtr;
  logic [3:0] rdPtr;
  logic [3:0] next_wrPtr;
  logic [3:0] next_rdPtr;
  logic [3:0] next_count;
  logic       doPush;
  logic       doPop;

  assign pushReady = count != 4'(fsp_pkg::FIFO_DEPTH);
  assign popValid  = count != 4'h0;
  assign popData   = mem[rdPtr];
  assign doPush    = pushValid && pushReady && !clear;
  assign doPop     = popValid && popReady && !clear;

  // Pointer wrap at ten entries
  always_comb begin
    next_wrPtr = wrPtr;
    next_rdPtr = rdPtr;
    next_count = count;
    if (clear) begin
      next_wrPtr = 4'h0;
      next_rdPtr = 4'h0;
      next_count = 4'h0;
    end else begin
      if (doPush) next_wrPtr = (wrPtr == 4'(fsp_pkg::FIFO_DEPTH - 1)) ? 4'h0 : wrPtr + 4'h1;
      if (doPop) next_rdPtr = (rdPtr == 4'(fsp_pkg::FIFO_DEPTH - 1)) ? 4'h0 : rdPtr + 4'h1;
      next_count = count + {3'h0, doPush} - {3'h0, doPop};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wrPtr <= 4'h0;
      rdPtr <= 4'h0;
      count <= 4'h0;
    end else begin
      wrPtr <= next_wrPtr;
      rdPtr <= next_rdPtr;
      count <= next_count;
    end
  end

  // Storage needs no reset
  always_ff @(posedge clk) begin
    if (doPush) mem[wrPtr] <= pushData;
  end
endmodule
`default_nettype wire

// ==== tb/fsp_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// Host end of the slave link
module fsp_host_model (
  input  wire logic        clk,
  output logic             slaveStrobeN,
  output logic [4:0]       hostStatusCode,
  output logic             hostRead,
  output logic [31:0]      hostDataIn,
  input  wire logic [31:0] hostDataOut,
  input  wire logic        hostDataOe
);
  // Idle bus before the first cycle
  initial begin
    slaveStrobeN = 1'b1;
    hostStatusCode = 5'h00;
    hostRead = 1'b0;
    hostDataIn = 32'h00000000;
  end
  // One strobed cycle; lines hold until the sampling edge
  task automatic xfer(input logic [4:0] code, input logic rd, input logic [31:0] wd,
                      output logic [31:0] rdat, output logic oe);
    @(posedge clk);
    slaveStrobeN <= 1'b0;
    hostStatusCode <= code;
    hostRead <= rd;
    hostDataIn <= wd;
    @(posedge clk);
    slaveStrobeN <= 1'b1;
    // Released lines must not keep showing the last word
    hostDataIn <= ~wd;
    hostStatusCode <= ~code;
    @(posedge clk);
    rdat = hostDataOut;
    oe = hostDataOe;
  endtask
endmodule
`default_nettype wire

// ==== tb/fsp_slave_port_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module fsp_slave_port_test;
  logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, e, oe;
  logic        strobeN, hostRead, doneN, reqN, dOe, bInv;
  logic [4:0]  code;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, din, dout, rd;
  int          failures, samples_checked;

  fsp_slave_port i_fsp_slave_port (.clk(clk), .rst_n(rst_n), .bclkInv(bInv),
    .slaveStrobeN(strobeN), .hostStatusCode(code), .hostRead(hostRead), .hostDataIn(din),
    .hostDataOut(dout), .hostDataOe(dOe), .slaveDoneN(doneN), .statusRequestN(reqN),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));
  fsp_host_model i_host (.clk(clk), .slaveStrobeN(strobeN), .hostStatusCode(code),
    .hostRead(hostRead), .hostDataIn(din), .hostDataOut(dout), .hostDataOe(dOe));

  // 250 MHz bench clock
  initial clk = 1'b0;
  always #2 clk = ~clk;

  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // APB transfer; waits on pready, never on a fixed count
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      failures++;
      stop_test();
    end
    rd = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Pulse must appear soon and last exactly one clock
  task automatic pulse(input logic trap);
    int n;
    n = 0;
    while (n < 20 && (trap ? reqN : doneN) !== 1'b0) begin
      @(posedge clk);
      n++;
    end
    check({31'h0, n < 20}, 32'h1);
    @(posedge clk);
    check({31'h0, trap ? reqN : doneN}, 32'h1);
  endtask

  // Hang guard
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    stop_test();
  end

  // Main sequence
  initial begin
    rst_n = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    bInv = 1'b0;
    failures = 0;
    samples_checked = 0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    check({30'h0, doneN, reqN}, 32'h3);
    apb(1'b0, fsp_pkg::A_FSR, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, 12'h040, 32'h0);
    check({31'h0, e}, 32'h1);
    // Memory to memory single add, result read back
    i_host.xfer(fsp_pkg::ST_ID, 1'b0, 32'hbe01c600, rd, oe);
    i_host.xfer(fsp_pkg::ST_OPER, 1'b0, 32'h3f800000, rd, oe);
    i_host.xfer(fsp_pkg::ST_OPER, 1'b0, 32'h40000000, rd, oe);
    apb(1'b0, fsp_pkg::A_STAT, 32'h0);
    check({18'h0, rd[13], 9'h0, rd[5:2]}, 32'h2);
    apb(1'b0, fsp_pkg::A_OPLO, 32'h0);
    check(rd, 32'h3f800000);
    apb(1'b1, fsp_pkg::A_RESLO, 32'h40400000);
    apb(1'b1, fsp_pkg::A_CTRL, 32'h2);
    pulse(1'b0);
    i_host.xfer(fsp_pkg::ST_OPER, 1'b1, 32'h0, rd, oe);
    check({31'h0, oe}, 32'h1);
    check(rd, 32'h40400000);
    // New instruction while operands are missing aborts the old one
    i_host.xfer(fsp_pkg::ST_ID, 1'b0, 32'hbe01c600, rd, oe);
    i_host.xfer(fsp_pkg::ST_OPER, 1'b0, 32'h11111111, rd, oe);
    i_host.xfer(fsp_pkg::ST_ID, 1'b0, 32'hbe01c600, rd, oe);
    apb(1'b0, fsp_pkg::A_STAT, 32'h0);
    check({20'h0, rd[31:24], rd[5:2]}, 32'h10);
    i_host.xfer(fsp_pkg::ST_OPER, 1'b0, 32'h22222222, rd, oe);
    i_host.xfer(fsp_pkg::ST_STAT, 1'b0, 32'h0, rd, oe);
    apb(1'b0, fsp_pkg::A_STAT, 32'h0);
    check({26'h0, rd[5:0]}, 32'h0);
    i_host.xfer(fsp_pkg::ST_OPER, 1'b1, 32'h0, rd, oe);
    check({31'h0, oe}, 32'h0);
    // Register to register add, trapped with both trap types
    for (int t = 0; t < 2; t++) begin
      i_host.xfer(fsp_pkg::ST_ID, 1'b0, 32'hbe010000, rd, oe);
      apb(1'b0, fsp_pkg::A_STAT, 32'h0);
      check({28'h0, rd[5:2]}, 32'h0);
      apb(1'b1, fsp_pkg::A_CTRL, {28'h0, t[0], 3'h4});
      pulse(1'b1);
      i_host.xfer(fsp_pkg::ST_STAT, 1'b1, 32'h0, rd, oe);
      check({30'h0, rd[1:0]}, {30'h0, t[0], 1'b1});
    end
    // Pipelined mode: four register adds in flight, then one completion
    apb(1'b1, fsp_pkg::A_CTRL, 32'h1);
    for (int k = 0; k < 4; k++) begin
      i_host.xfer(fsp_pkg::ST_ID, 1'b0, 32'hbe010000, rd, oe);
    end
    apb(1'b0, fsp_pkg::A_STAT, 32'h0);
    check({29'h0, rd[8:6]}, 32'h4);
    apb(1'b1, fsp_pkg::A_CTRL, 32'h3);
    pulse(1'b0);
    apb(1'b0, fsp_pkg::A_STAT, 32'h0);
    check({29'h0, rd[8:6]}, 32'h3);
    i_host.xfer(fsp_pkg::ST_STAT, 1'b0, 32'h0, rd, oe);
    // Complement clock seen high at a rising edge is flagged
    bInv <= 1'b1;
    @(posedge clk);
    bInv <= 1'b0;
    apb(1'b0, fsp_pkg::A_STAT, 32'h0);
    check({31'h0, rd[13]}, 32'h1);
    stop_test();
  end
endmodule
`default_nettype wire
